// File: core/emce_engine.sv
// Purpose: Memory function command engine behind a single-wire slot front end
// Assumes: Slots, bus resets and programming pulses arrive as same-clock pulses
// Notes:   EPROM cells are modelled as registers that can only clear bits, except the top status byte
`timescale 1ns/1ps
`default_nettype none
module emce_engine
  import emce_pkg::*;
#(
  parameter int DATA_DEPTH = DATA_BYTES,
  parameter int STAT_DEPTH = STAT_BYTES
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire emce_slot_s   slot,
  input  wire logic         busReset,
  input  wire logic         progPulse,
  output emce_answer_s      answer,
  output logic              cmdActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Status index of the redirection byte for the page holding an address
  function automatic logic [2:0] redirIdx(input logic [15:0] a);
    redirIdx = {1'b0, a[6:5]} + REDIR_BASE;
  endfunction : redirIdx

  // Counter step with wrap at the chosen last bit
  function automatic logic [3:0] cntNext(input logic [3:0] c, input logic [3:0] last);
    cntNext = (c == last) ? CNT_ZERO : c + CNT_STEP;
  endfunction : cntNext

  ////////////////////////////////////////////////////////////////////////////
  // State

  emce_state_e  state_r,   state_nxt;
  logic [3:0]   bitCnt_r,  bitCnt_nxt;
  logic [7:0]   cmd_r,     cmd_nxt;
  logic [15:0]  addr_r,    addr_nxt;
  logic [7:0]   scratch_r, scratch_nxt;
  logic         lastPage_r, lastPage_nxt;
  logic         ansBit_r,  ansBit_nxt;
  logic         ansVld_r,  ansVld_nxt;
  logic         active_r,  active_nxt;

  logic [7:0]   dataMem [DATA_DEPTH];
  logic [7:0]   statMem [STAT_DEPTH];

  // CRC generator hookup
  logic         crcClr;
  logic         crcLoad;
  logic [15:0]  crcLoadVal;
  logic         crcShift;
  logic         crcBit;
  logic [15:0]  crcVal;

  // Memory write strobes
  logic         dataWr;
  logic         statWr;
  logic [7:0]   dataWrVal;
  logic [7:0]   statWrVal;

  // Slot decoding and memory views
  logic         isRd;
  logic         isWr;
  logic         addrBit;
  logic         isStatCmd;
  logic [7:0]   dataByte;
  logic [7:0]   statByte;
  logic [7:0]   redirByte;
  logic [7:0]   verifyByte;
  logic [15:0]  addrInc;

  assign isRd       = slot.valid & slot.isRead;
  assign isWr       = slot.valid & ~slot.isRead;
  assign isStatCmd  = (cmd_r == CMD_WRITE_STAT);
  assign dataByte   = dataMem[addr_r[6:0]];
  assign statByte   = statMem[addr_r[2:0]];
  assign redirByte  = statMem[redirIdx(addr_r)];
  assign verifyByte = isStatCmd ? statByte : dataByte;
  assign addrInc    = addr_r + ADDR_STEP;
  // Upper address bits of a data write are dropped before they reach the CRC
  assign addrBit    = ((cmd_r == CMD_WRITE_MEM) && (bitCnt_r >= DATA_ADDR_BITS)) ? 1'b0 : slot.wrBit;

  emce_crc16 u_crc (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (crcClr),
    .load     (crcLoad),
    .loadVal  (crcLoadVal),
    .shiftEn  (crcShift),
    .shiftBit (crcBit),
    .crcVal   (crcVal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer, next values
  always_comb begin
    state_nxt    = state_r;
    bitCnt_nxt   = bitCnt_r;
    cmd_nxt      = cmd_r;
    addr_nxt     = addr_r;
    scratch_nxt  = scratch_r;
    lastPage_nxt = lastPage_r;
    ansBit_nxt   = 1'b1;       // Idle or out-of-turn read slots see ones
    ansVld_nxt   = isRd;
    crcClr       = 1'b0;
    crcLoad      = 1'b0;
    crcLoadVal   = addrInc;
    crcShift     = 1'b0;
    crcBit       = 1'b0;
    dataWr       = 1'b0;
    statWr       = 1'b0;
    dataWrVal    = dataByte & scratch_r;
    // Top status byte is plain storage; its top bit never takes a write
    statWrVal    = (addr_r[2:0] == STAT_SRAM_IDX) ? {statByte[7], scratch_r[6:0]} : (statByte & scratch_r);

    case (state_r)
      ST_CMD: begin
        if (isWr) begin
          cmd_nxt    = {slot.wrBit, cmd_r[7:1]};
          crcShift   = 1'b1;
          crcBit     = slot.wrBit;
          bitCnt_nxt = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            state_nxt = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        if (isWr) begin
          addr_nxt   = {addrBit, addr_r[15:1]};
          crcShift   = 1'b1;
          crcBit     = addrBit;
          bitCnt_nxt = cntNext(bitCnt_r, WORD_LAST_BIT);
          if (bitCnt_r == WORD_LAST_BIT) begin
            // Unknown codes are parked until the next bus reset
            case (cmd_r)
              CMD_READ_MEM:   state_nxt = ST_RD_DATA;
              CMD_EXT_READ:   state_nxt = ST_XR_REDIR;
              CMD_WRITE_MEM:  state_nxt = ST_WR_DATA;
              CMD_WRITE_STAT: state_nxt = ST_WR_DATA;
              default:        state_nxt = ST_IGNORE;
            endcase
          end
        end
      end
      ST_RD_DATA: begin
        if (isRd) begin
          ansBit_nxt = dataByte[bitCnt_r[2:0]];
          crcShift   = 1'b1;
          crcBit     = dataByte[bitCnt_r[2:0]];
          bitCnt_nxt = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            addr_nxt = addrInc;
            if (addr_r[6:0] == DATA_LAST_IDX) begin
              state_nxt = ST_RD_CRC;
            end
          end
        end
      end
      ST_RD_CRC: begin
        if (isRd) begin
          ansBit_nxt = ~crcVal[bitCnt_r];
          bitCnt_nxt = cntNext(bitCnt_r, WORD_LAST_BIT);
          if (bitCnt_r == WORD_LAST_BIT) begin
            state_nxt = ST_ONES;
          end
        end
      end
      ST_XR_REDIR: begin
        if (isRd) begin
          ansBit_nxt = redirByte[bitCnt_r[2:0]];
          crcShift   = 1'b1;
          crcBit     = redirByte[bitCnt_r[2:0]];
          bitCnt_nxt = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            state_nxt = ST_XR_HCRC;
          end
        end
      end
      ST_XR_HCRC: begin
        if (isRd) begin
          ansBit_nxt = ~crcVal[bitCnt_r];
          bitCnt_nxt = cntNext(bitCnt_r, WORD_LAST_BIT);
          if (bitCnt_r == WORD_LAST_BIT) begin
            crcClr    = 1'b1;
            state_nxt = ST_XR_DATA;
          end
        end
      end
      ST_XR_DATA: begin
        if (isRd) begin
          ansBit_nxt = dataByte[bitCnt_r[2:0]];
          crcShift   = 1'b1;
          crcBit     = dataByte[bitCnt_r[2:0]];
          bitCnt_nxt = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            addr_nxt = addrInc;
            if (addr_r[4:0] == PAGE_LAST_OFS) begin
              lastPage_nxt = (addr_r[6:0] == DATA_LAST_IDX);
              state_nxt    = ST_XR_PCRC;
            end
          end
        end
      end
      ST_XR_PCRC: begin
        if (isRd) begin
          ansBit_nxt = ~crcVal[bitCnt_r];
          bitCnt_nxt = cntNext(bitCnt_r, WORD_LAST_BIT);
          if (bitCnt_r == WORD_LAST_BIT) begin
            crcClr    = 1'b1;
            state_nxt = lastPage_r ? ST_ONES : ST_XR_REDIR;
          end
        end
      end
      ST_WR_DATA: begin
        if (isWr) begin
          scratch_nxt = {slot.wrBit, scratch_r[7:1]};
          crcShift    = 1'b1;
          crcBit      = slot.wrBit;
          bitCnt_nxt  = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            state_nxt = ST_WR_CRC;
          end
        end
      end
      ST_WR_CRC: begin
        if (isRd) begin
          ansBit_nxt = ~crcVal[bitCnt_r];
          bitCnt_nxt = cntNext(bitCnt_r, WORD_LAST_BIT);
          if (bitCnt_r == WORD_LAST_BIT) begin
            state_nxt = ST_WR_PROG;
          end
        end
      end
      ST_WR_PROG: begin
        // No CRC verdict exists here; the pulse alone commits the byte
        if (progPulse) begin
          dataWr    = ~isStatCmd;
          statWr    = isStatCmd;
          state_nxt = ST_WR_VERIFY;
        end
      end
      ST_WR_VERIFY: begin
        if (isRd) begin
          ansBit_nxt = verifyByte[bitCnt_r[2:0]];
          bitCnt_nxt = cntNext(bitCnt_r, BYTE_LAST_BIT);
          if (bitCnt_r == BYTE_LAST_BIT) begin
            addr_nxt  = addrInc;
            crcLoad   = 1'b1;
            state_nxt = ST_WR_DATA;
          end
        end
      end
      ST_ONES: begin
        // Answer stays one until the next bus reset
      end
      ST_IGNORE: begin
      end
      default: begin
        state_nxt = ST_CMD;
      end
    endcase

    // Bus reset wins over state, count, CRC and writes; a read slot this cycle still gets its bit
    if (busReset) begin
      state_nxt    = ST_CMD;
      bitCnt_nxt   = CNT_ZERO;
      crcClr       = 1'b1;
      crcLoad      = 1'b0;
      crcShift     = 1'b0;
      lastPage_nxt = 1'b0;
      dataWr       = 1'b0;
      statWr       = 1'b0;
    end
    active_nxt = (state_nxt != ST_CMD) || (bitCnt_nxt != CNT_ZERO);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= ST_CMD;
      bitCnt_r   <= CNT_ZERO;
      cmd_r      <= 8'h00;
      addr_r     <= 16'h0000;
      scratch_r  <= ERASED_BYTE;
      lastPage_r <= 1'b0;
      ansBit_r   <= 1'b1;
      ansVld_r   <= 1'b0;
      active_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bitCnt_r   <= bitCnt_nxt;
      cmd_r      <= cmd_nxt;
      addr_r     <= addr_nxt;
      scratch_r  <= scratch_nxt;
      lastPage_r <= lastPage_nxt;
      ansBit_r   <= ansBit_nxt;
      ansVld_r   <= ansVld_nxt;
      active_r   <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // EPROM arrays; reset stands in for a fresh, erased part
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < DATA_DEPTH; i++) begin
        dataMem[i] <= ERASED_BYTE;
      end
      for (int j = 0; j < STAT_DEPTH; j++) begin
        statMem[j] <= ERASED_BYTE;
      end
    end else begin
      if (dataWr) begin
        dataMem[addr_r[6:0]] <= dataWrVal;
      end
      if (statWr) begin
        statMem[addr_r[2:0]] <= statWrVal;
      end
    end
  end

  assign answer.valid  = ansVld_r;
  assign answer.bitVal = ansBit_r;
  assign cmdActive     = active_r;

endmodule : emce_engine
`default_nettype wire

// File: common/emce_pkg.sv
// Purpose: Shared constants, types and states of the memory command engine
// Assumes: Slot decoding and bus reset detection are done by a bit-level front end
// Notes:   All multi-bit fields travel least significant bit first on the wire
package emce_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_READ_MEM    = 8'hF0;
  localparam logic [7:0] CMD_EXT_READ    = 8'hA5;
  localparam logic [7:0] CMD_WRITE_MEM   = 8'h0F;
  localparam logic [7:0] CMD_WRITE_STAT  = 8'h55;

  ////////////////////////////////////////////////////////////////////////////
  // Memory geometry
  localparam int         DATA_BYTES      = 128;
  localparam int         STAT_BYTES      = 8;
  localparam logic [6:0] DATA_LAST_IDX   = 7'h7F;
  localparam logic [4:0] PAGE_LAST_OFS   = 5'h1F;
  localparam logic [2:0] REDIR_BASE      = 3'h1;
  localparam logic [2:0] STAT_SRAM_IDX   = 3'h7;
  localparam logic [3:0] DATA_ADDR_BITS  = 4'h7;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam logic [15:0] ADDR_STEP      = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counting
  localparam logic [3:0] BYTE_LAST_BIT   = 4'h7;
  localparam logic [3:0] WORD_LAST_BIT   = 4'hF;
  localparam logic [3:0] CNT_STEP        = 4'h1;
  localparam logic [3:0] CNT_ZERO        = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // CRC16, reflected form of x^16+x^15+x^2+1
  localparam logic [15:0] CRC_POLY_REFL  = 16'hA001;
  localparam logic [15:0] CRC_CLEAR      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_CMD,
    ST_ADDR,
    ST_RD_DATA,
    ST_RD_CRC,
    ST_ONES,
    ST_XR_REDIR,
    ST_XR_HCRC,
    ST_XR_DATA,
    ST_XR_PCRC,
    ST_WR_DATA,
    ST_WR_CRC,
    ST_WR_PROG,
    ST_WR_VERIFY,
    ST_IGNORE
  } emce_state_e;

  // One bus time slot, as decoded by the front end
  typedef struct packed {
    logic valid;   // One-cycle pulse per slot
    logic isRead;  // 1: read slot, 0: write slot
    logic wrBit;   // Bit sent by the master in a write slot
  } emce_slot_s;

  // Answer to a read slot
  typedef struct packed {
    logic valid;
    logic bitVal;
  } emce_answer_s;

endpackage : emce_pkg

// File: core/emce_crc16.sv
// Purpose: Serial CRC16 generator with clear, preload and one-bit shift
// Assumes: Clear beats preload, preload beats shift
// Notes:   Remainder is kept uninverted; the engine inverts on output
`timescale 1ns/1ps
`default_nettype none
module emce_crc16
  import emce_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [15:0] loadVal,
  input  wire logic        shiftEn,
  input  wire logic        shiftBit,
  output logic      [15:0] crcVal
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic        feedback;

  // Next remainder, LSB-first shifting
  always_comb begin
    feedback = crc_r[0] ^ shiftBit;
    crc_nxt  = crc_r;
    if (clr) begin
      crc_nxt = CRC_CLEAR;
    end else if (load) begin
      crc_nxt = loadVal;
    end else if (shiftEn) begin
      crc_nxt = {1'b0, crc_r[15:1]} ^ (feedback ? CRC_POLY_REFL : CRC_CLEAR);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      crc_r <= CRC_CLEAR;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crcVal = crc_r;

endmodule : emce_crc16
`default_nettype wire

// File: testbench/emce_engine_sva.sv
// Purpose: Port-level checks of the memory command engine
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Attached to every engine instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module emce_engine_sva
  import emce_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire emce_slot_s   slot,
  input  wire logic         busReset,
  input  wire logic         progPulse,
  input  wire emce_answer_s answer,
  input  wire logic         cmdActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Read slot decode shared by several checks
  logic rdSlot;
  assign rdSlot = slot.valid & slot.isRead;

  ////////////////////////////////////////
  // Slot answering
  a_read_answered: assert property (rdSlot |=> answer.valid)
    else $error("read slot left unanswered");
  a_no_stray_answer: assert property (!rdSlot |=> !answer.valid)
    else $error("answer without a read slot");
  a_idle_read_one: assert property (!cmdActive && rdSlot |=> answer.bitVal)
    else $error("read before any command answered zero");
  a_abort_read_one: assert property (busReset ##1 !slot.valid ##1 rdSlot |=> answer.bitVal)
    else $error("read after bus reset answered zero");

  ////////////////////////////////////////
  // Command activity tracking
  a_bit_arms: assert property (slot.valid && !slot.isRead && !busReset |=> cmdActive)
    else $error("write slot did not start a command");
  a_active_holds: assert property (cmdActive && !busReset |=> cmdActive)
    else $error("command dropped without bus reset");
  a_abort_clears: assert property (busReset |=> !cmdActive)
    else $error("bus reset did not abort command");
  a_release_idle: assert property ($fell(reset) |-> !cmdActive && !answer.valid && answer.bitVal)
    else $error("outputs not idle after reset");
endmodule : emce_engine_sva

bind emce_engine emce_engine_sva u_emce_engine_sva (
  .core_clk (core_clk),
  .reset    (reset),
  .slot     (slot),
  .busReset (busReset),
  .progPulse(progPulse),
  .answer   (answer),
  .cmdActive(cmdActive)
);
`default_nettype wire

// File: testbench/emce_bus_master.sv
// Purpose: Behavioural bus master issuing decoded slots and pulses
// Assumes: Slot answer arrives within two cycles of the slot
// Notes:   A missing answer shows up as an unknown bit
`timescale 1ns/1ps
`default_nettype none
module emce_bus_master
  import emce_pkg::*;
(
  input  wire logic         core_clk,
  input  wire emce_answer_s answer,
  output var  emce_slot_s   slot,
  output var  logic         busReset,
  output var  logic         progPulse
);
  int   idleGap = 0; // Raised to play a slow master
  logic lastBit;

  initial begin
    slot      = '0;
    busReset  = 1'b0;
    progPulse = 1'b0;
  end

  // One slot; the idle bit toggles so stale data is never reused
  task automatic pulse_slot(input logic isRd, input logic b);
    @(posedge core_clk);
    #1;
    slot = '{valid: 1'b1, isRead: isRd, wrBit: b};
    @(posedge core_clk);
    #1;
    slot = '{valid: 1'b0, isRead: 1'b0, wrBit: ~b};
    if (isRd && !answer.valid) begin
      @(posedge core_clk);
      #1;
    end
    lastBit = answer.valid ? answer.bitVal : 1'bx;
    repeat (idleGap) @(posedge core_clk);
  endtask : pulse_slot

  task automatic send8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      pulse_slot(1'b0, v[i]);
    end
  endtask : send8

  task automatic send16(input logic [15:0] v);
    send8(v[7:0]);
    send8(v[15:8]);
  endtask : send16

  task automatic recv8(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      pulse_slot(1'b1, 1'b1);
      v[i] = lastBit;
    end
  endtask : recv8

  task automatic recv16(output logic [15:0] v);
    recv8(v[7:0]);
    recv8(v[15:8]);
  endtask : recv16

  // Bus reset or end of a programming pulse, one cycle wide
  task automatic strobe(input logic isProg);
    @(posedge core_clk);
    #1;
    progPulse = isProg;
    busReset  = ~isProg;
    @(posedge core_clk);
    #1;
    progPulse = 1'b0;
    busReset  = 1'b0;
  endtask : strobe
endmodule : emce_bus_master
`default_nettype wire

// File: testbench/emce_engine_tb_top.sv
// Purpose: Self-checking bench of the memory command engine
// Assumes: Master model drives every engine input except clock and reset
// Notes:   Expected memory and CRC values are kept locally
`timescale 1ns/1ps
`default_nettype none
module emce_engine_tb_top
  import emce_pkg::*;
;
  logic         core_clk;
  logic         reset;
  emce_slot_s   slot;
  logic         busReset;
  logic         progPulse;
  emce_answer_s answer;
  logic         cmdActive;
  int           nMismatch   = 0;
  int           comparisons = 0;
  logic [7:0]   expMem [128] = '{default: 8'hFF};
  logic [7:0]   expStat [8]  = '{default: 8'hFF};

  emce_engine u_emce_engine (
    .core_clk (core_clk),
    .reset    (reset),
    .slot     (slot),
    .busReset (busReset),
    .progPulse(progPulse),
    .answer   (answer),
    .cmdActive(cmdActive)
  );

  emce_bus_master bm (
    .core_clk (core_clk),
    .answer   (answer),
    .slot     (slot),
    .busReset (busReset),
    .progPulse(progPulse)
  );

  ////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc8

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (nMismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  // Plain read to the field end, CRC, then idle ones
  task automatic sc_plain_read(input logic [15:0] start);
    logic [15:0] crc, v;
    logic [6:0]  a;
    crc = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_MEM), start[7:0]), start[15:8]);
    bm.send8(CMD_READ_MEM);
    bm.send16(start);
    a = start[6:0];
    do begin
      bm.recv8(v[7:0]);
      check(v[7:0], expMem[a]);
      crc = crc8(crc, expMem[a]);
      a++;
    end while (a != 7'h00);
    bm.recv16(v);
    check(v, ~crc);
    bm.recv16(v);
    check(v, 16'hFFFF);
    bm.strobe(1'b0);
  endtask : sc_plain_read

  // Two write passes with CRC, pulse and verify each
  task automatic sc_write(input logic [7:0] cmd, input logic [15:0] start, input logic [7:0] d0,
                          input logic [7:0] d1);
    logic [15:0] crc, v, adr;
    logic [7:0]  d;
    adr = (cmd == CMD_WRITE_MEM) ? {9'h000, start[6:0]} : start;
    crc = crc8(crc8(crc8(CRC_CLEAR, cmd), adr[7:0]), adr[15:8]);
    bm.send8(cmd);
    bm.send16(start);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? d0 : d1;
      bm.send8(d);
      bm.recv16(v);
      check(v, ~crc8(crc, d));
      bm.strobe(1'b1);
      if (cmd == CMD_WRITE_MEM) begin
        expMem[adr[6:0]] = expMem[adr[6:0]] & d;
      end else if (adr[2:0] == 3'h7) begin
        // Top status byte is plain storage: low bits replaced, top bit kept
        expStat[7] = {expStat[7][7], d[6:0]};
      end else begin
        expStat[adr[2:0]] = expStat[adr[2:0]] & d;
      end
      bm.recv8(v[7:0]);
      check(v[7:0], (cmd == CMD_WRITE_MEM) ? expMem[adr[6:0]] : expStat[adr[2:0]]);
      adr = adr + ADDR_STEP;
      crc = adr;
    end
    bm.strobe(1'b0);
  endtask : sc_write

  // Read cut short by bus reset, then a slow master reads the last byte
  task automatic sc_abort;
    logic [15:0] v;
    bm.send8(CMD_READ_MEM);
    bm.send16(16'h0010);
    bm.recv8(v[7:0]);
    check(v[7:0], expMem[7'h10]);
    bm.strobe(1'b0);
    bm.recv8(v[7:0]);
    check(v[7:0], 8'hFF);
    bm.strobe(1'b0);
    bm.idleGap = 3;
    sc_plain_read(16'h007F);
    bm.idleGap = 0;
  endtask : sc_abort

  // Unknown command parks the engine; reads give ones, not the stored zeros
  task automatic sc_ignore;
    logic [15:0] v;
    bm.send8(8'hC3);
    bm.send16(16'h0010);
    bm.recv16(v);
    check(v, 16'hFFFF);
    bm.strobe(1'b0);
  endtask : sc_ignore

  // Extended read over one page end
  task automatic sc_ext_read(input logic [15:0] start);
    logic [15:0] crc, v;
    logic [6:0]  a;
    logic [7:0]  rd;
    a = start[6:0];
    rd = expStat[{1'b0, a[6:5]} + 3'h1];
    crc = crc8(crc8(crc8(crc8(CRC_CLEAR, CMD_EXT_READ), start[7:0]), start[15:8]), rd);
    bm.send8(CMD_EXT_READ);
    bm.send16(start);
    bm.recv8(v[7:0]);
    check(v[7:0], rd);
    bm.recv16(v);
    check(v, ~crc);
    crc = CRC_CLEAR;
    do begin
      bm.recv8(v[7:0]);
      check(v[7:0], expMem[a]);
      crc = crc8(crc, expMem[a]);
      a++;
    end while (a[4:0] != 5'h00);
    bm.recv16(v);
    check(v, ~crc);
    if (a == 7'h00) begin
      bm.recv16(v);
      check(v, 16'hFFFF);
    end else begin
      rd = expStat[{1'b0, a[6:5]} + 3'h1];
      bm.recv8(v[7:0]);
      check(v[7:0], rd);
      bm.recv16(v);
      check(v, ~crc8(CRC_CLEAR, rd));
      bm.recv8(v[7:0]);
      check(v[7:0], expMem[a]);
    end
    bm.strobe(1'b0);
  endtask : sc_ext_read

  ////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    nMismatch++;
    stop_test;
  end

  initial begin
    reset = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    sc_plain_read(16'h007E);
    sc_write(CMD_WRITE_MEM, 16'h0290, 8'hA5, 8'h3C);
    sc_write(CMD_WRITE_MEM, 16'h0010, 8'h5A, 8'hFF);
    sc_write(CMD_WRITE_STAT, 16'h0002, 8'hFC, 8'hFE);
    sc_abort;
    sc_ext_read(16'h001E);
    sc_ext_read(16'h003F);
    sc_ext_read(16'h007E);
    sc_write(CMD_WRITE_STAT, 16'h0007, 8'h00, 8'hFE);
    sc_write(CMD_WRITE_STAT, 16'h0007, 8'h7F, 8'hFF);
    sc_ignore;
    stop_test;
  end
endmodule : emce_engine_tb_top
`default_nettype wire
